//--- mmu_prot_pkg.sv
/*
 Constants shared by the access protection checker and its helpers.
 Assumes a 32-bit APB register bus and 8-bit process identifiers.
*/
// Summary of operation
// - Fetch checks need instruction translation on; data checks need data translation on.
// - Non-zero entry identifier must equal current process identifier, else deny.
// - Entry identifier zero matches any process; other checks still apply.
// - Fetch from non-executable page is tagged; interrupt only on execution attempt.
// - Tagged instruction discarded without execution raises no interrupt.
// - Valid matching data entry grants reads; write permit governs writes.
// - Any store, cache zero or invalidate, to unwritable page faults, unless zone overrides.
// - Reads on a matching page are denied only by a no-access zone.
// - Entry carries 4-bit zone select, sixteen zones, any pages per zone.
// - Zone n selects 2-bit field n, field 0 in the top bit pair.
// - Writing a zone field changes all its pages for following checks.
// - Problem state, zone 00 denies loads, stores and execution.
// - Problem state, zone 01/10 keep entry permits; 11 grants execute and write.
// - Supervisor state, zone 00/01 keep entry permits; 10/11 grant both.
// - Same checks apply to cache operations and string loads and stores.
// - Cache block allocate never faults; a would-be fault becomes a no-op.
// - Data access with no valid matching entry raises data miss, not fault.
package mmu_prot_pkg;

    // ----------------------------------------
    // Widths
    // ----------------------------------------
    localparam int APB_ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int ID_W = 8;
    localparam int SEL_W = 4;
    localparam int ZONE_COUNT = 16;
    localparam int ZONE_FIELD_W = 2;
    localparam int STATE_W = 3;
    localparam int INT_W = 4;

    // ----------------------------------------
    // Register offsets
    // ----------------------------------------
    localparam logic [APB_ADDR_W-1:0] OFF_PROC = 8'h00;
    localparam logic [APB_ADDR_W-1:0] OFF_ZMAP = 8'h04;
    localparam logic [APB_ADDR_W-1:0] OFF_STATE = 8'h08;
    localparam logic [APB_ADDR_W-1:0] OFF_INT_STATUS = 8'h0C;
    localparam logic [APB_ADDR_W-1:0] OFF_INT_CLEAR = 8'h10;
    localparam logic [APB_ADDR_W-1:0] OFF_INT_ENABLE = 8'h14;

    // ----------------------------------------
    // Reset values
    // ----------------------------------------
    localparam logic [ID_W-1:0] PROC_RESET = 8'h00;
    localparam logic [DATA_W-1:0] ZMAP_RESET = 32'h0000_0000;
    localparam logic [STATE_W-1:0] STATE_RESET = 3'h0;
    localparam logic [INT_W-1:0] INT_RESET = 4'h0;
    localparam logic [ID_W-1:0] ID_SHARED = 8'h00;

    // ----------------------------------------
    // Field positions
    // ----------------------------------------
    localparam int ST_ITE = 0;
    localparam int ST_DTE = 1;
    localparam int ST_PROB = 2;
    localparam int INT_ISI = 0;
    localparam int INT_DSI = 1;
    localparam int INT_DMISS = 2;
    localparam int INT_NOOP = 3;

    // ----------------------------------------
    // Zone field codes
    // ----------------------------------------
    localparam logic [ZONE_FIELD_W-1:0] ZONE_00 = 2'h0;
    localparam logic [ZONE_FIELD_W-1:0] ZONE_01 = 2'h1;
    localparam logic [ZONE_FIELD_W-1:0] ZONE_10 = 2'h2;
    localparam logic [ZONE_FIELD_W-1:0] ZONE_11 = 2'h3;

endpackage

//--- zone_field_pick.sv
/*
 Picks one 2-bit zone field out of the zone protection map.
 Assumes zone select comes straight from the matched entry.
*/
`timescale 1ns/10ps
module zone_field_pick
(
    input wire logic [mmu_prot_pkg::DATA_W-1:0] zone_protection_map,
    input wire logic [mmu_prot_pkg::SEL_W-1:0] zone_select,
    output logic [mmu_prot_pkg::ZONE_FIELD_W-1:0] zone_field
);

    // ----------------------------------------
    // Field split
    // ----------------------------------------
    logic [mmu_prot_pkg::ZONE_FIELD_W-1:0] fields [mmu_prot_pkg::ZONE_COUNT];

    // Big-endian numbering: field 0 is the top pair
    for (genvar n = 0; n < mmu_prot_pkg::ZONE_COUNT; n++)
    begin : g_field
        assign fields[n] = zone_protection_map[mmu_prot_pkg::DATA_W-1-mmu_prot_pkg::ZONE_FIELD_W*n -:
            mmu_prot_pkg::ZONE_FIELD_W];
    end

    assign zone_field = fields[zone_select];

endmodule // zone_field_pick

//--- access_perm_eval.sv
/*
 Grants or denies one access from entry fields, zone field and state.
 Assumes the caller qualifies the result with translation enable and hit.
*/
`timescale 1ns/10ps
module access_perm_eval
(
    input wire logic problem_state_flag,
    input wire logic [mmu_prot_pkg::ZONE_FIELD_W-1:0] zone_field,
    input wire logic [mmu_prot_pkg::ID_W-1:0] translation_identifier,
    input wire logic [mmu_prot_pkg::ID_W-1:0] process_identifier,
    input wire logic execute_permit,
    input wire logic write_permit,
    input wire logic need_execute,
    input wire logic need_write,
    output logic granted
);

    logic id_ok;
    logic no_access;
    logic override;

    // Shared pages still go through zone and permit checks
    assign id_ok = (translation_identifier == mmu_prot_pkg::ID_SHARED)
        || (translation_identifier == process_identifier);
    assign no_access = problem_state_flag && (zone_field == mmu_prot_pkg::ZONE_00);
    assign override = problem_state_flag ? (zone_field == mmu_prot_pkg::ZONE_11)
        : ((zone_field == mmu_prot_pkg::ZONE_10) || (zone_field == mmu_prot_pkg::ZONE_11));

    // Reads need only identity and a zone that is not closed
    assign granted = id_ok && !no_access
        && (!need_execute || execute_permit || override)
        && (!need_write || write_permit || override);

endmodule // access_perm_eval

//--- mmu_access_protection_check.sv
/*
 Access protection checker: APB registers, fetch and data permission paths,
 sticky interrupt status with enable and write-one clear.
 Assumes lookup results and entry fields arrive from core logic on pclk.
*/
`timescale 1ns/10ps
module mmu_access_protection_check
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [mmu_prot_pkg::APB_ADDR_W-1:0] paddr,
    input wire logic [mmu_prot_pkg::DATA_W-1:0] pwdata,
    output logic [mmu_prot_pkg::DATA_W-1:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic fetch_valid,
    input wire logic fetch_hit,
    input wire logic [mmu_prot_pkg::ID_W-1:0] fetch_ident,
    input wire logic fetch_execute_permit,
    input wire logic [mmu_prot_pkg::SEL_W-1:0] fetch_zone_select,
    output logic fetch_error_tag,
    input wire logic exec_attempt,
    input wire logic exec_error_tag,
    output logic instr_storage_int,
    input wire logic data_valid,
    input wire logic data_hit,
    input wire logic [mmu_prot_pkg::ID_W-1:0] data_ident,
    input wire logic data_write_permit,
    input wire logic [mmu_prot_pkg::SEL_W-1:0] data_zone_select,
    input wire logic data_is_store,
    input wire logic data_is_alloc,
    output logic data_deny,
    output logic data_storage_int,
    output logic data_miss_int,
    output logic data_alloc_noop,
    output logic irq
);

    // ----------------------------------------
    // Declarations
    // ----------------------------------------
    logic [mmu_prot_pkg::ID_W-1:0] process_identifier;
    logic [mmu_prot_pkg::DATA_W-1:0] zone_protection_map;
    logic [mmu_prot_pkg::STATE_W-1:0] machine_state_reg;
    logic [mmu_prot_pkg::INT_W-1:0] int_status;
    logic [mmu_prot_pkg::INT_W-1:0] int_enable;
    logic [mmu_prot_pkg::INT_W-1:0] int_events;
    logic [mmu_prot_pkg::INT_W-1:0] int_clear;
    logic [mmu_prot_pkg::INT_W-1:0] next_int_status;
    logic [mmu_prot_pkg::DATA_W-1:0] next_prdata;
    logic instr_translate_enable;
    logic data_translate_enable;
    logic problem_state_flag;
    logic addr_mapped;
    logic apb_write;
    logic apb_setup;
    logic [mmu_prot_pkg::ZONE_FIELD_W-1:0] fetch_zone_field;
    logic [mmu_prot_pkg::ZONE_FIELD_W-1:0] data_zone_field;
    logic fetch_granted;
    logic data_granted;
    logic data_checked;

    assign instr_translate_enable = machine_state_reg[mmu_prot_pkg::ST_ITE];
    assign data_translate_enable = machine_state_reg[mmu_prot_pkg::ST_DTE];
    assign problem_state_flag = machine_state_reg[mmu_prot_pkg::ST_PROB];

    // ----------------------------------------
    // APB decode
    // ----------------------------------------
    // Zero wait states; unmapped addresses answer with an error
    assign pready = 1'b1;
    assign apb_setup = psel && !penable;
    assign apb_write = psel && penable && pwrite && addr_mapped;
    assign pslverr = psel && penable && !addr_mapped;

    always_comb
    begin
        addr_mapped = 1'b1;
        next_prdata = '0;
        unique case (paddr)
            mmu_prot_pkg::OFF_PROC:
            begin
                next_prdata[mmu_prot_pkg::ID_W-1:0] = process_identifier;
            end
            mmu_prot_pkg::OFF_ZMAP:
            begin
                next_prdata = zone_protection_map;
            end
            mmu_prot_pkg::OFF_STATE:
            begin
                next_prdata[mmu_prot_pkg::STATE_W-1:0] = machine_state_reg;
            end
            mmu_prot_pkg::OFF_INT_STATUS:
            begin
                next_prdata[mmu_prot_pkg::INT_W-1:0] = int_status;
            end
            mmu_prot_pkg::OFF_INT_CLEAR:
            begin
                // Write-only: reads return zero
                next_prdata = '0;
            end
            mmu_prot_pkg::OFF_INT_ENABLE:
            begin
                next_prdata[mmu_prot_pkg::INT_W-1:0] = int_enable;
            end
            default:
            begin
                addr_mapped = 1'b0;
            end
        endcase
    end

    // Read data captured in the setup cycle, stable through access
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prdata <= '0;
        end
        else if (apb_setup && !pwrite)
        begin
            prdata <= next_prdata;
        end
    end

    // ----------------------------------------
    // Registers
    // ----------------------------------------
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            process_identifier <= mmu_prot_pkg::PROC_RESET;
        end
        else if (apb_write && paddr == mmu_prot_pkg::OFF_PROC)
        begin
            process_identifier <= pwdata[mmu_prot_pkg::ID_W-1:0];
        end
    end

    // No per-entry rewrite: every check reads the live map
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            zone_protection_map <= mmu_prot_pkg::ZMAP_RESET;
        end
        else if (apb_write && paddr == mmu_prot_pkg::OFF_ZMAP)
        begin
            zone_protection_map <= pwdata;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            machine_state_reg <= mmu_prot_pkg::STATE_RESET;
        end
        else if (apb_write && paddr == mmu_prot_pkg::OFF_STATE)
        begin
            machine_state_reg <= pwdata[mmu_prot_pkg::STATE_W-1:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            int_enable <= mmu_prot_pkg::INT_RESET;
        end
        else if (apb_write && paddr == mmu_prot_pkg::OFF_INT_ENABLE)
        begin
            int_enable <= pwdata[mmu_prot_pkg::INT_W-1:0];
        end
    end

    // ----------------------------------------
    // Fetch path
    // ----------------------------------------
    zone_field_pick u_fetch_zone
    (
        .zone_protection_map(zone_protection_map),
        .zone_select(fetch_zone_select),
        .zone_field(fetch_zone_field)
    );

    access_perm_eval u_fetch_perm
    (
        .problem_state_flag(problem_state_flag),
        .zone_field(fetch_zone_field),
        .translation_identifier(fetch_ident),
        .process_identifier(process_identifier),
        .execute_permit(fetch_execute_permit),
        .write_permit(1'b1),
        .need_execute(1'b1),
        .need_write(1'b0),
        .granted(fetch_granted)
    );

    // Tag only; the fault waits for an execution attempt
    assign fetch_error_tag = instr_translate_enable && fetch_valid && fetch_hit && !fetch_granted;
    assign instr_storage_int = exec_attempt && exec_error_tag;

    // ----------------------------------------
    // Data path
    // ----------------------------------------
    zone_field_pick u_data_zone
    (
        .zone_protection_map(zone_protection_map),
        .zone_select(data_zone_select),
        .zone_field(data_zone_field)
    );

    // Cache operations and string accesses arrive as plain loads or stores
    access_perm_eval u_data_perm
    (
        .problem_state_flag(problem_state_flag),
        .zone_field(data_zone_field),
        .translation_identifier(data_ident),
        .process_identifier(process_identifier),
        .execute_permit(1'b1),
        .write_permit(data_write_permit),
        .need_execute(1'b0),
        .need_write(data_is_store),
        .granted(data_granted)
    );

    assign data_checked = data_translate_enable && data_valid;
    assign data_deny = data_checked && data_hit && !data_granted;
    assign data_storage_int = data_deny && !data_is_alloc;
    // Allocate would only pre-zero a line, so dropping it is harmless
    assign data_alloc_noop = data_deny && data_is_alloc;
    assign data_miss_int = data_checked && !data_hit;

    // ----------------------------------------
    // Interrupt status
    // ----------------------------------------
    always_comb
    begin
        int_events = '0;
        int_events[mmu_prot_pkg::INT_ISI] = instr_storage_int;
        int_events[mmu_prot_pkg::INT_DSI] = data_storage_int;
        int_events[mmu_prot_pkg::INT_DMISS] = data_miss_int;
        int_events[mmu_prot_pkg::INT_NOOP] = data_alloc_noop;
    end

    assign int_clear = (apb_write && paddr == mmu_prot_pkg::OFF_INT_CLEAR)
        ? pwdata[mmu_prot_pkg::INT_W-1:0] : '0;
    // Set wins over a clear in the same cycle
    assign next_int_status = (int_status & ~int_clear) | int_events;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            int_status <= mmu_prot_pkg::INT_RESET;
        end
        else
        begin
            int_status <= next_int_status;
        end
    end

    assign irq = |(int_status & int_enable);

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    sequence s_zmap_write;
        psel && penable && pwrite && paddr == mmu_prot_pkg::OFF_ZMAP;
    endsequence

    sequence s_exec_bad;
        exec_attempt && exec_error_tag;
    endsequence

    sequence s_data_look;
        data_translate_enable && data_valid && data_hit && !data_is_alloc;
    endsequence

    property p_translate_off;
        !instr_translate_enable && !data_translate_enable |->
            !fetch_error_tag && !data_deny && !data_miss_int;
    endproperty
    a_translate_off: assert property (p_translate_off)
        else $error("check active with translation off");

    property p_id_mismatch;
        s_data_look ##0 (data_ident != mmu_prot_pkg::ID_SHARED && data_ident != process_identifier)
            |-> data_storage_int ##1 int_status[mmu_prot_pkg::INT_DSI];
    endproperty
    a_id_mismatch: assert property (p_id_mismatch)
        else $error("identifier mismatch not denied");

    property p_shared_load;
        s_data_look ##0 (data_ident == mmu_prot_pkg::ID_SHARED && !data_is_store
            && data_zone_field != mmu_prot_pkg::ZONE_00) |-> !data_deny;
    endproperty
    a_shared_load: assert property (p_shared_load)
        else $error("shared page load denied");

    property p_exec_fault;
        s_exec_bad |-> instr_storage_int ##1 int_status[mmu_prot_pkg::INT_ISI];
    endproperty
    a_exec_fault: assert property (p_exec_fault)
        else $error("tagged execution without fault");

    property p_discard_quiet;
        !exec_attempt |-> !instr_storage_int;
    endproperty
    a_discard_quiet: assert property (p_discard_quiet)
        else $error("fault without execution attempt");

    property p_store_protect;
        s_data_look ##0 (data_is_store && !data_write_permit && !problem_state_flag
            && data_zone_field == mmu_prot_pkg::ZONE_01) |-> data_storage_int;
    endproperty
    a_store_protect: assert property (p_store_protect)
        else $error("store to unwritable page allowed");

    property p_problem_closed;
        s_data_look ##0 (problem_state_flag && data_zone_field == mmu_prot_pkg::ZONE_00)
            |-> data_storage_int;
    endproperty
    a_problem_closed: assert property (p_problem_closed)
        else $error("closed zone access allowed");

    property p_zone_write;
        s_zmap_write |=> zone_protection_map == $past(pwdata);
    endproperty
    a_zone_write: assert property (p_zone_write)
        else $error("zone map write lost");

    property p_alloc_quiet;
        data_is_alloc |-> !data_storage_int;
    endproperty
    a_alloc_quiet: assert property (p_alloc_quiet)
        else $error("allocate raised storage fault");

    property p_data_miss;
        data_translate_enable && data_valid && !data_hit |-> data_miss_int && !data_deny
            ##1 int_status[mmu_prot_pkg::INT_DMISS];
    endproperty
    a_data_miss: assert property (p_data_miss)
        else $error("miss not reported");

endmodule // mmu_access_protection_check

//--- core_pipe_model.sv
/*
 Core fetch and execute stage model: carries the fetch error tag to execute.
 Assumes fetch lookups are driven on pclk and the checker returns the tag.
*/
`timescale 1ns/10ps
module core_pipe_model
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic fetch_valid,
    input wire logic fetch_error_tag,
    input wire logic run_fetched,
    output logic exec_attempt,
    output logic exec_error_tag
);
    // ----------------------------------------
    // Execute stage
    // ----------------------------------------
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            exec_attempt <= 1'b0;
            exec_error_tag <= 1'b0;
        end
        else
        begin
            // Tag kept on discard; the checker must gate on the attempt
            exec_attempt <= fetch_valid && run_fetched;
            exec_error_tag <= fetch_valid && fetch_error_tag;
        end
    end
endmodule // core_pipe_model

//--- test_mmu_access_protection_check.sv
/*
 Self-checking bench: APB register tasks, lookup driver, execute stage model.
 Assumes same-cycle decisions and status one cycle after each event.
*/
`timescale 1ns/10ps
module test_mmu_access_protection_check;
    // ----------------------------------------
    // Signals
    // ----------------------------------------
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic fetch_valid = 1'b0;
    logic fetch_hit = 1'b0;
    logic [7:0] fetch_ident = 8'h00;
    logic fetch_execute_permit = 1'b0;
    logic [3:0] fetch_zone_select = 4'h0;
    logic fetch_error_tag;
    logic run_fetched = 1'b0;
    logic exec_attempt;
    logic exec_error_tag;
    logic instr_storage_int;
    logic data_valid = 1'b0;
    logic data_hit = 1'b0;
    logic [7:0] data_ident = 8'h00;
    logic data_write_permit = 1'b0;
    logic [3:0] data_zone_select = 4'h0;
    logic data_is_store = 1'b0;
    logic data_is_alloc = 1'b0;
    logic data_deny;
    logic data_storage_int;
    logic data_miss_int;
    logic data_alloc_noop;
    logic irq;
    int fails = 0;
    int samples_checked = 0;
    logic [31:0] rd;
    logic err;

    always #2 pclk = ~pclk;

    mmu_access_protection_check u_dut
    (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .fetch_valid(fetch_valid),
        .fetch_hit(fetch_hit), .fetch_ident(fetch_ident), .fetch_execute_permit(fetch_execute_permit),
        .fetch_zone_select(fetch_zone_select), .fetch_error_tag(fetch_error_tag), .exec_attempt(exec_attempt),
        .exec_error_tag(exec_error_tag), .instr_storage_int(instr_storage_int), .data_valid(data_valid),
        .data_hit(data_hit), .data_ident(data_ident), .data_write_permit(data_write_permit),
        .data_zone_select(data_zone_select), .data_is_store(data_is_store), .data_is_alloc(data_is_alloc),
        .data_deny(data_deny), .data_storage_int(data_storage_int), .data_miss_int(data_miss_int),
        .data_alloc_noop(data_alloc_noop), .irq(irq)
    );

    core_pipe_model u_core
    (
        .pclk(pclk), .presetn(presetn), .fetch_valid(fetch_valid), .fetch_error_tag(fetch_error_tag),
        .run_fetched(run_fetched), .exec_attempt(exec_attempt), .exec_error_tag(exec_error_tag)
    );

    // ----------------------------------------
    // Tasks
    // ----------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            fails++;
            $display("ERROR %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic chk1(input logic got, input logic exp);
        chk({31'h0, got}, {31'h0, exp});
    endtask

    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd,
                       output logic err);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1)
            @(posedge pclk);
        chk1(pready, 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        #1;
    endtask

    task automatic wreg(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d, rd, err);
    endtask

    task automatic rreg(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0000_0000, rd, err);
        chk(rd, exp);
    endtask

    // One lookup per side; shared id, permit, zone
    task automatic drv(input logic f, input logic d, input logic [7:0] id, input logic perm, input logic [3:0] zs,
                       input logic st, input logic al, input logic hit, input logic run);
        @(posedge pclk);
        fetch_valid <= f;
        data_valid <= d;
        fetch_hit <= 1'b1;
        data_hit <= hit;
        fetch_ident <= id;
        data_ident <= id;
        fetch_execute_permit <= perm;
        data_write_permit <= perm;
        fetch_zone_select <= zs;
        data_zone_select <= zs;
        data_is_store <= st;
        data_is_alloc <= al;
        run_fetched <= run;
        #1;
    endtask

    task automatic tally_and_finish;
        $display("Checks %0d mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0)
        begin
            $display("SIMULATION PASSED");
        end
        else
        begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // ----------------------------------------
    // Sequence
    // ----------------------------------------
    initial
    begin
        logic [31:0] map;
        logic [3:0] zs;
        logic noacc;
        logic ovr;
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        for (int a = 0; a < 24; a += 4)
        begin
            rreg(8'(a), 32'h0000_0000);
        end
        apb(1'b0, 8'h18, 32'h0000_0000, rd, err);
        chk1(err, 1'b1);
        chk(rd, 32'h0000_0000);
        wreg(mmu_prot_pkg::OFF_PROC, 32'hFFFF_FF2A);
        rreg(mmu_prot_pkg::OFF_PROC, 32'h0000_002A);
        // Tag faults only when executed
        wreg(mmu_prot_pkg::OFF_STATE, 32'h0000_0001);
        drv(1'b1, 1'b0, 8'h2A, 1'b0, 4'h0, 1'b0, 1'b0, 1'b1, 1'b1);
        chk1(fetch_error_tag, 1'b1);
        chk1(instr_storage_int, 1'b0);
        drv(1'b0, 1'b0, 8'h2A, 1'b0, 4'h0, 1'b0, 1'b0, 1'b1, 1'b0);
        chk1(instr_storage_int, 1'b1);
        drv(1'b1, 1'b0, 8'h2A, 1'b0, 4'h0, 1'b0, 1'b0, 1'b1, 1'b0);
        drv(1'b0, 1'b0, 8'h2A, 1'b0, 4'h0, 1'b0, 1'b0, 1'b1, 1'b0);
        chk1(instr_storage_int, 1'b0);
        rreg(mmu_prot_pkg::OFF_INT_STATUS, 32'h0000_0001);
        // Each side gated by its own enable
        drv(1'b1, 1'b1, 8'h2A, 1'b0, 4'h0, 1'b1, 1'b0, 1'b0, 1'b0);
        chk1(data_miss_int, 1'b0);
        drv(1'b1, 1'b1, 8'h2A, 1'b0, 4'h0, 1'b1, 1'b0, 1'b1, 1'b0);
        chk1(data_deny, 1'b0);
        wreg(mmu_prot_pkg::OFF_STATE, 32'h0000_0002);
        drv(1'b1, 1'b1, 8'h2A, 1'b0, 4'h0, 1'b1, 1'b0, 1'b1, 1'b0);
        chk1(fetch_error_tag, 1'b0);
        chk1(data_deny, 1'b1);
        // All zone codes, both states; other fields differ
        for (int p = 0; p < 2; p++)
        begin
            for (int z = 0; z < 4; z++)
            begin
                zs = 4'(z * 5);
                map = {16{2'(3 - z)}};
                map[31 - 2 * zs -: 2] = 2'(z);
                wreg(mmu_prot_pkg::OFF_STATE, {29'h0, p[0], 2'b11});
                wreg(mmu_prot_pkg::OFF_ZMAP, map);
                noacc = (p == 1) && (z == 0);
                ovr = (p == 1) ? (z == 3) : (z >= 2);
                drv(1'b1, 1'b1, 8'h2A, 1'b0, zs, 1'b1, 1'b0, 1'b1, 1'b0);
                chk1(fetch_error_tag, noacc || !ovr);
                chk1(data_deny, noacc || !ovr);
                drv(1'b1, 1'b1, 8'h2A, 1'b1, zs, 1'b0, 1'b0, 1'b1, 1'b0);
                chk1(fetch_error_tag, noacc);
                chk1(data_deny, noacc);
            end
        end
        // Identifier, shared page, zone rewrite
        wreg(mmu_prot_pkg::OFF_STATE, 32'h0000_0003);
        wreg(mmu_prot_pkg::OFF_ZMAP, 32'h0300_0000);
        drv(1'b1, 1'b1, 8'h2A, 1'b1, 4'h3, 1'b1, 1'b0, 1'b1, 1'b0);
        chk1(data_deny, 1'b0);
        drv(1'b1, 1'b1, 8'h2B, 1'b1, 4'h3, 1'b0, 1'b0, 1'b1, 1'b0);
        chk1(data_deny, 1'b1);
        chk1(fetch_error_tag, 1'b1);
        drv(1'b1, 1'b1, 8'h00, 1'b1, 4'h3, 1'b1, 1'b0, 1'b1, 1'b0);
        chk1(data_deny, 1'b0);
        wreg(mmu_prot_pkg::OFF_STATE, 32'h0000_0007);
        wreg(mmu_prot_pkg::OFF_ZMAP, 32'h0000_0000);
        drv(1'b0, 1'b1, 8'h00, 1'b1, 4'h3, 1'b0, 1'b0, 1'b1, 1'b0);
        chk1(data_deny, 1'b1);
        wreg(mmu_prot_pkg::OFF_ZMAP, 32'h0100_0000);
        drv(1'b0, 1'b1, 8'h00, 1'b1, 4'h3, 1'b0, 1'b0, 1'b1, 1'b0);
        chk1(data_deny, 1'b0);
        // Allocate, miss, store; status and irq
        wreg(mmu_prot_pkg::OFF_STATE, 32'h0000_0002);
        wreg(mmu_prot_pkg::OFF_ZMAP, 32'h0000_0000);
        wreg(mmu_prot_pkg::OFF_INT_CLEAR, 32'h0000_000F);
        rreg(mmu_prot_pkg::OFF_INT_STATUS, 32'h0000_0000);
        wreg(mmu_prot_pkg::OFF_INT_ENABLE, 32'h0000_000F);
        chk1(irq, 1'b0);
        drv(1'b0, 1'b1, 8'h2A, 1'b0, 4'h3, 1'b1, 1'b1, 1'b1, 1'b0);
        chk1(data_alloc_noop, 1'b1);
        chk1(data_storage_int, 1'b0);
        drv(1'b0, 1'b1, 8'h2A, 1'b0, 4'h3, 1'b0, 1'b1, 1'b0, 1'b0);
        chk1(data_miss_int, 1'b1);
        chk1(data_deny, 1'b0);
        drv(1'b0, 1'b1, 8'h2A, 1'b0, 4'h3, 1'b1, 1'b0, 1'b1, 1'b0);
        chk1(data_storage_int, 1'b1);
        drv(1'b0, 1'b0, 8'h2A, 1'b0, 4'h3, 1'b0, 1'b0, 1'b1, 1'b0);
        rreg(mmu_prot_pkg::OFF_INT_STATUS, 32'h0000_000E);
        chk1(irq, 1'b1);
        wreg(mmu_prot_pkg::OFF_INT_ENABLE, 32'h0000_0000);
        chk1(irq, 1'b0);
        wreg(mmu_prot_pkg::OFF_INT_ENABLE, 32'h0000_0004);
        chk1(irq, 1'b1);
        wreg(mmu_prot_pkg::OFF_INT_CLEAR, 32'h0000_0004);
        chk1(irq, 1'b0);
        wreg(mmu_prot_pkg::OFF_INT_STATUS, 32'h0000_000F);
        rreg(mmu_prot_pkg::OFF_INT_STATUS, 32'h0000_000A);
        rreg(mmu_prot_pkg::OFF_INT_CLEAR, 32'h0000_0000);
        tally_and_finish();
    end

    // Whole sequence needs well under a thousand cycles
    initial
    begin
        repeat (20000) @(posedge pclk);
        fails++;
        tally_and_finish();
    end
endmodule // test_mmu_access_protection_check
